//--- src/xmac_map.svh
// Opcode encodings, field positions and reset values of the MAC unit
`ifndef XMAC_MAP_SVH
`define XMAC_MAP_SVH

// Extended operation codes as presented by instruction decode
`define XM_CODE_HALF_MAC_SINGLE 4'h0
`define XM_CODE_HALF_MAC_DOUBLE 4'h1
`define XM_CODE_WORD_MAC_SINGLE 4'h2
`define XM_CODE_WORD_MAC_DOUBLE 4'h3
`define XM_CODE_WORD_MSUB_SINGLE 4'h4
`define XM_CODE_WORD_MSUB_DOUBLE 4'h5
`define XM_CODE_WORD_MUL_SINGLE 4'h6
`define XM_CODE_SIGNED_MUL_DOUBLE 4'h7
`define XM_CODE_UNSIGNED_MUL_DOUBLE 4'h8

// Overflow exception disable bit in the float control register
`define XM_FCR_OVF_DIS_BIT 16

// Halfword field positions inside a word operand
`define XM_HI_MSB 31
`define XM_HI_LSB 16
`define XM_LO_MSB 15
`define XM_LO_LSB 0

// Reset values
`define XM_G_RST 32'h0000_0000
`define XM_LREG_RST 32'h0000_0000

// Issue-to-writeback latency in cycles (busy time)
`define XM_BUSY_CYCLES 2

`endif

//--- src/xmac_pkg.sv
// Types of the extended multiply-accumulate unit
package xmac_pkg;

  typedef enum logic [1:0] {
    XM_IDLE,
    XM_MUL,
    XM_ACC
  } xm_fsm_t;

  typedef enum logic [3:0] {
    XM_HALF_MAC_SINGLE,
    XM_HALF_MAC_DOUBLE,
    XM_WORD_MAC_SINGLE,
    XM_WORD_MAC_DOUBLE,
    XM_WORD_MSUB_SINGLE,
    XM_WORD_MSUB_DOUBLE,
    XM_WORD_MUL_SINGLE,
    XM_SIGNED_MUL_DOUBLE,
    XM_UNSIGNED_MUL_DOUBLE
  } xm_op_t;

  typedef struct packed {
    xm_fsm_t fsm;
    xm_op_t op;
    logic signed [65:0] prod;
    logic [31:0] g14;
    logic [31:0] g15;
    logic busy;
    logic wb_valid;
    logic wb_double;
    logic ovf;
  } xm_state_t;

  typedef struct packed {
    logic [15:0][31:0] mem;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
  } xm_lreg_state_t;

endpackage

//--- src/xmac_lreg_mem.sv
// Local register mirror with two registered read ports
`timescale 1ns/1ps
`include "xmac_map.svh"

module xmac_lreg_mem (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic re_i,
  input wire logic [3:0] raddr_a_i,
  input wire logic [3:0] raddr_b_i,
  output logic [31:0] rdata_a_o,
  output logic [31:0] rdata_b_o
);

  xmac_pkg::xm_lreg_state_t st;
  xmac_pkg::xm_lreg_state_t next_st;

  // Write-through bypass keeps a same-cycle update visible to the read
  function automatic logic [31:0] rd_word(
    input xmac_pkg::xm_lreg_state_t s, input logic [3:0] a,
    input logic w, input logic [3:0] wa, input logic [31:0] wd);
    rd_word = (w && wa == a) ? wd : s.mem[a];
  endfunction

  always_comb begin
    next_st = st;
    if (we_i) begin
      next_st.mem[waddr_i] = wdata_i;
    end
    if (re_i) begin
      next_st.rd_a = rd_word(st, raddr_a_i, we_i, waddr_i, wdata_i);
      next_st.rd_b = rd_word(st, raddr_b_i, we_i, waddr_i, wdata_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= '{mem: {16{`XM_LREG_RST}}, rd_a: `XM_LREG_RST,
              rd_b: `XM_LREG_RST};
    end else begin
      st <= next_st;
    end
  end

  assign rdata_a_o = st.rd_a;
  assign rdata_b_o = st.rd_b;

  property p_read_a;
    @(posedge core_clk_i) disable iff (rst_i)
    re_i && !(we_i && waddr_i == raddr_a_i)
      |=> rdata_a_o == $past(st.mem[raddr_a_i]);
  endproperty
  a_read_a: assert property (p_read_a)
    else $error("first operand read wrong local register");

endmodule

//--- src/xmac_unit.sv
// Extended DSP multiply-accumulate unit beside the core pipeline
// Function
// - Accept each op in one issue cycle
// - Single-word results go to global 15 only
// - Double results: 14 upper, 15 lower word
// - Never touch any status condition flag
// - Accumulate overflow traps only if control bit clear
// - Overflow exception signalled late, not precise
// - Operands picked from locals 0-15 by codes
// - Halfword products summed into global 15
// - Halfword product sum added into 14:15 pair
// - Full product added into global 15
// - Full 64-bit product added into pair
// - Product subtracted from global 15
// - 64-bit product subtracted from pair
// - Plain product into 15, no trap
// - Signed 64-bit product overwrites pair
// - Unsigned 64-bit product overwrites pair
`timescale 1ns/1ps
`include "xmac_map.svh"

module xmac_unit (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic issue_valid_i,
  input wire logic [3:0] op_code_i,
  input wire logic [3:0] first_local_operand_i,
  input wire logic [3:0] second_local_operand_i,
  input wire logic [31:0] float_control_register_i,
  input wire logic lreg_we_i,
  input wire logic [3:0] lreg_waddr_i,
  input wire logic [31:0] lreg_wdata_i,
  input wire logic g_we_i,
  input wire logic g_sel_15_i,
  input wire logic [31:0] g_wdata_i,
  output logic busy_o,
  output logic [31:0] global_register_14_o,
  output logic [31:0] global_register_15_o,
  output logic wb_valid_o,
  output logic wb_double_o,
  output logic ovf_exc_o
);

  xmac_pkg::xm_state_t st;
  xmac_pkg::xm_state_t next_st;
  logic issue_ok;
  logic [31:0] rd_a;
  logic [31:0] rd_b;
  logic signed [65:0] acc_in;
  logic signed [65:0] res;

  localparam xmac_pkg::xm_state_t XM_STATE_RST = '{
    fsm: xmac_pkg::XM_IDLE,
    op: xmac_pkg::XM_WORD_MUL_SINGLE,
    prod: 66'h0,
    g14: `XM_G_RST,
    g15: `XM_G_RST,
    busy: 1'b0,
    wb_valid: 1'b0,
    wb_double: 1'b0,
    ovf: 1'b0
  };

  function automatic logic op_legal(input logic [3:0] c);
    op_legal = (c <= `XM_CODE_UNSIGNED_MUL_DOUBLE);
  endfunction

  function automatic xmac_pkg::xm_op_t op_decode(input logic [3:0] c);
    unique case (c)
      `XM_CODE_HALF_MAC_SINGLE: op_decode = xmac_pkg::XM_HALF_MAC_SINGLE;
      `XM_CODE_HALF_MAC_DOUBLE: op_decode = xmac_pkg::XM_HALF_MAC_DOUBLE;
      `XM_CODE_WORD_MAC_SINGLE: op_decode = xmac_pkg::XM_WORD_MAC_SINGLE;
      `XM_CODE_WORD_MAC_DOUBLE: op_decode = xmac_pkg::XM_WORD_MAC_DOUBLE;
      `XM_CODE_WORD_MSUB_SINGLE: op_decode = xmac_pkg::XM_WORD_MSUB_SINGLE;
      `XM_CODE_WORD_MSUB_DOUBLE: op_decode = xmac_pkg::XM_WORD_MSUB_DOUBLE;
      `XM_CODE_WORD_MUL_SINGLE: op_decode = xmac_pkg::XM_WORD_MUL_SINGLE;
      `XM_CODE_SIGNED_MUL_DOUBLE:
        op_decode = xmac_pkg::XM_SIGNED_MUL_DOUBLE;
      `XM_CODE_UNSIGNED_MUL_DOUBLE:
        op_decode = xmac_pkg::XM_UNSIGNED_MUL_DOUBLE;
      default: op_decode = xmac_pkg::XM_WORD_MUL_SINGLE;
    endcase
  endfunction

  function automatic logic is_double(input xmac_pkg::xm_op_t o);
    is_double = (o == xmac_pkg::XM_HALF_MAC_DOUBLE) ||
                (o == xmac_pkg::XM_WORD_MAC_DOUBLE) ||
                (o == xmac_pkg::XM_WORD_MSUB_DOUBLE) ||
                (o == xmac_pkg::XM_SIGNED_MUL_DOUBLE) ||
                (o == xmac_pkg::XM_UNSIGNED_MUL_DOUBLE);
  endfunction

  // Only adding and subtracting variants may trap on overflow
  function automatic logic is_accum(input xmac_pkg::xm_op_t o);
    is_accum = (o == xmac_pkg::XM_HALF_MAC_SINGLE) ||
               (o == xmac_pkg::XM_HALF_MAC_DOUBLE) ||
               (o == xmac_pkg::XM_WORD_MAC_SINGLE) ||
               (o == xmac_pkg::XM_WORD_MAC_DOUBLE) ||
               (o == xmac_pkg::XM_WORD_MSUB_SINGLE) ||
               (o == xmac_pkg::XM_WORD_MSUB_DOUBLE);
  endfunction

  function automatic logic is_sub(input xmac_pkg::xm_op_t o);
    is_sub = (o == xmac_pkg::XM_WORD_MSUB_SINGLE) ||
             (o == xmac_pkg::XM_WORD_MSUB_DOUBLE);
  endfunction

  function automatic logic signed [65:0] smul(input logic [31:0] a,
                                             input logic [31:0] b);
    smul = 66'($signed(a)) * 66'($signed(b));
  endfunction

  function automatic logic signed [65:0] umul(input logic [31:0] a,
                                             input logic [31:0] b);
    umul = $signed(66'(a)) * $signed(66'(b));
  endfunction

  // Sum of the upper-half and lower-half signed products
  function automatic logic signed [65:0] hmul(input logic [31:0] a,
                                             input logic [31:0] b);
    logic signed [65:0] hi;
    logic signed [65:0] lo;
    hi = 66'($signed(a[`XM_HI_MSB:`XM_HI_LSB])) *
         66'($signed(b[`XM_HI_MSB:`XM_HI_LSB]));
    lo = 66'($signed(a[`XM_LO_MSB:`XM_LO_LSB])) *
         66'($signed(b[`XM_LO_MSB:`XM_LO_LSB]));
    hmul = hi + lo;
  endfunction

  xmac_lreg_mem u_lreg (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .we_i(lreg_we_i),
    .waddr_i(lreg_waddr_i),
    .wdata_i(lreg_wdata_i),
    .re_i(issue_ok),
    .raddr_a_i(first_local_operand_i),
    .raddr_b_i(second_local_operand_i),
    .rdata_a_o(rd_a),
    .rdata_b_o(rd_b)
  );

  // Issue needs the idle state and a legal code; operands are fetched on that edge
  assign issue_ok = issue_valid_i && (st.fsm == xmac_pkg::XM_IDLE) &&
                    op_legal(op_code_i);

  // Accumulator source: global 15 alone or the 14:15 pair
  always_comb begin
    if (is_double(st.op)) begin
      acc_in = 66'($signed({st.g14, st.g15}));
    end else begin
      acc_in = 66'($signed(st.g15));
    end
  end

  always_comb begin
    if (!is_accum(st.op)) begin
      res = st.prod;
    end else if (is_sub(st.op)) begin
      res = acc_in - st.prod;
    end else begin
      res = acc_in + st.prod;
    end
  end

  always_comb begin
    next_st = st;
    next_st.wb_valid = 1'b0;
    next_st.ovf = 1'b0;
    unique case (st.fsm)
      xmac_pkg::XM_IDLE: begin
        if (issue_ok) begin
          next_st.fsm = xmac_pkg::XM_MUL;
          next_st.op = op_decode(op_code_i);
          next_st.busy = 1'b1;
        end else if (g_we_i) begin
          // Core moves into 14/15 only while no result is pending
          if (g_sel_15_i) begin
            next_st.g15 = g_wdata_i;
          end else begin
            next_st.g14 = g_wdata_i;
          end
        end
      end
      xmac_pkg::XM_MUL: begin
        next_st.fsm = xmac_pkg::XM_ACC;
        if (st.op == xmac_pkg::XM_HALF_MAC_SINGLE ||
            st.op == xmac_pkg::XM_HALF_MAC_DOUBLE) begin
          next_st.prod = hmul(rd_a, rd_b);
        end else if (st.op == xmac_pkg::XM_UNSIGNED_MUL_DOUBLE) begin
          next_st.prod = umul(rd_a, rd_b);
        end else begin
          next_st.prod = smul(rd_a, rd_b);
        end
      end
      xmac_pkg::XM_ACC: begin
        next_st.fsm = xmac_pkg::XM_IDLE;
        next_st.busy = 1'b0;
        next_st.wb_valid = 1'b1;
        next_st.wb_double = is_double(st.op);
        // Result only reaches 14/15; flags live in the core untouched
        if (is_double(st.op)) begin
          next_st.g14 = res[63:32];
          next_st.g15 = res[31:0];
          next_st.ovf = is_accum(st.op) &&
                        !float_control_register_i[`XM_FCR_OVF_DIS_BIT] &&
                        (res[65:63] != 3'h0) &&
                        (res[65:63] != 3'h7);
        end else begin
          next_st.g15 = res[31:0];
          next_st.ovf = is_accum(st.op) &&
                        !float_control_register_i[`XM_FCR_OVF_DIS_BIT] &&
                        (res[65:31] != 35'h0) &&
                        (res[65:31] != 35'h7_FFFF_FFFF);
        end
      end
      default: begin
        next_st = XM_STATE_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= XM_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o = st.busy;
  assign global_register_14_o = st.g14;
  assign global_register_15_o = st.g15;
  assign wb_valid_o = st.wb_valid;
  assign wb_double_o = st.wb_double;
  assign ovf_exc_o = st.ovf;

  property p_issue_one_cycle;
    @(posedge core_clk_i) disable iff (rst_i)
    issue_valid_i && !busy_o && op_legal(op_code_i) |=> busy_o;
  endproperty
  a_issue_one_cycle: assert property (p_issue_one_cycle)
    else $error("legal issue not taken in one cycle");

  property p_busy_span;
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(busy_o) |-> busy_o[*2] ##1 (!busy_o && wb_valid_o);
  endproperty
  a_busy_span: assert property (p_busy_span)
    else $error("busy window not two cycles ending in writeback");

  // Moves into 14 must not slip in while a single result is pending
  property p_stall_holds_g14;
    @(posedge core_clk_i) disable iff (rst_i)
    busy_o && !$past(busy_o) |-> ##2 wb_valid_o && (wb_double_o ||
      (global_register_14_o == $past(global_register_14_o, 2)));
  endproperty
  a_stall_holds_g14: assert property (p_stall_holds_g14)
    else $error("global 14 changed during a pending single result");

  property p_single_keeps_g14;
    @(posedge core_clk_i) disable iff (rst_i)
    wb_valid_o && !wb_double_o |->
      global_register_14_o == $past(global_register_14_o);
  endproperty
  a_single_keeps_g14: assert property (p_single_keeps_g14)
    else $error("single-word result disturbed global 14");

  property p_signed_double;
    @(posedge core_clk_i) disable iff (rst_i)
    wb_valid_o && $past(st.op) == xmac_pkg::XM_SIGNED_MUL_DOUBLE |->
      {global_register_14_o, global_register_15_o} ==
      64'($signed($past(rd_a, 2)) * $signed($past(rd_b, 2)));
  endproperty
  a_signed_double: assert property (p_signed_double)
    else $error("signed double product wrong in 14:15");

  property p_unsigned_double;
    @(posedge core_clk_i) disable iff (rst_i)
    wb_valid_o && $past(st.op) == xmac_pkg::XM_UNSIGNED_MUL_DOUBLE |->
      {global_register_14_o, global_register_15_o} ==
      64'(64'($past(rd_a, 2)) * 64'($past(rd_b, 2))) && !ovf_exc_o;
  endproperty
  a_unsigned_double: assert property (p_unsigned_double)
    else $error("unsigned double product wrong in 14:15");

  property p_word_mul;
    @(posedge core_clk_i) disable iff (rst_i)
    wb_valid_o && $past(st.op) == xmac_pkg::XM_WORD_MUL_SINGLE |->
      global_register_15_o == 32'($past(rd_a, 2) * $past(rd_b, 2)) &&
      !ovf_exc_o;
  endproperty
  a_word_mul: assert property (p_word_mul)
    else $error("single product wrong or trapped");

  property p_word_mac;
    @(posedge core_clk_i) disable iff (rst_i)
    wb_valid_o && $past(st.op) == xmac_pkg::XM_WORD_MAC_SINGLE |->
      global_register_15_o == 32'($past(global_register_15_o) +
      32'($past(rd_a, 2) * $past(rd_b, 2)));
  endproperty
  a_word_mac: assert property (p_word_mac)
    else $error("single accumulate result wrong");

  property p_word_msub;
    @(posedge core_clk_i) disable iff (rst_i)
    wb_valid_o && $past(st.op) == xmac_pkg::XM_WORD_MSUB_SINGLE |->
      global_register_15_o == 32'($past(global_register_15_o) -
      32'($past(rd_a, 2) * $past(rd_b, 2)));
  endproperty
  a_word_msub: assert property (p_word_msub)
    else $error("single subtract result wrong");

  property p_ovf_gated;
    @(posedge core_clk_i) disable iff (rst_i)
    ovf_exc_o |-> wb_valid_o &&
      !$past(float_control_register_i[`XM_FCR_OVF_DIS_BIT]) &&
      is_accum($past(st.op));
  endproperty
  a_ovf_gated: assert property (p_ovf_gated)
    else $error("overflow exception raised while disabled");

  // Unknown codes leave the unit idle
  property p_illegal_refused;
    @(posedge core_clk_i) disable iff (rst_i)
    issue_valid_i && !busy_o && !op_legal(op_code_i) |=> !busy_o;
  endproperty
  a_illegal_refused: assert property (p_illegal_refused)
    else $error("illegal code started an operation");

  property p_half_mac_single;
    @(posedge core_clk_i) disable iff (rst_i)
    wb_valid_o && $past(st.op) == xmac_pkg::XM_HALF_MAC_SINGLE |->
      global_register_15_o ==
      32'($signed($past(global_register_15_o)) +
      $signed($past(rd_a[31:16], 2)) * $signed($past(rd_b[31:16], 2)) +
      $signed($past(rd_a[15:0], 2)) * $signed($past(rd_b[15:0], 2)));
  endproperty
  a_half_mac_single: assert property (p_half_mac_single)
    else $error("halfword single accumulate result wrong");

endmodule

//--- dv/xmac_core_model.sv
// Core-side model: local registers, global moves and op issue
`timescale 1ns/1ps
module xmac_core_model (
  input wire logic core_clk_i,
  output logic issue_valid_o,
  output logic [3:0] op_code_o,
  output logic [3:0] first_local_operand_o,
  output logic [3:0] second_local_operand_o,
  output logic [31:0] float_control_register_o,
  output logic lreg_we_o,
  output logic [3:0] lreg_waddr_o,
  output logic [31:0] lreg_wdata_o,
  output logic g_we_o,
  output logic g_sel_15_o,
  output logic [31:0] g_wdata_o
);
  logic [31:0] loc [16];

  initial begin
    issue_valid_o = 1'b0;
    op_code_o = 4'h0;
    first_local_operand_o = 4'h0;
    second_local_operand_o = 4'h0;
    float_control_register_o = 32'h0000_0000;
    lreg_we_o = 1'b0;
    lreg_waddr_o = 4'h0;
    lreg_wdata_o = 32'h0000_0000;
    g_we_o = 1'b0;
    g_sel_15_o = 1'b0;
    g_wdata_o = 32'h0000_0000;
  end

  // Released data lines show the inverse of the last value
  task automatic write_local(input logic [3:0] idx, input logic [31:0] v);
    @(posedge core_clk_i);
    lreg_we_o <= 1'b1;
    lreg_waddr_o <= idx;
    lreg_wdata_o <= v;
    loc[idx] = v;
    @(posedge core_clk_i);
    lreg_we_o <= 1'b0;
    lreg_wdata_o <= ~v;
  endtask

  task automatic move_global(input logic sel, input logic [31:0] v);
    @(posedge core_clk_i);
    g_we_o <= 1'b1;
    g_sel_15_o <= sel;
    g_wdata_o <= v;
    @(posedge core_clk_i);
    g_we_o <= 1'b0;
    g_wdata_o <= ~v;
  endtask

  // Operands only from locals 0..15 by two codes
  task automatic issue_op(input logic [3:0] op, input logic [3:0] a,
      input logic [3:0] b);
    @(posedge core_clk_i);
    issue_valid_o <= 1'b1;
    op_code_o <= op;
    first_local_operand_o <= a;
    second_local_operand_o <= b;
    @(posedge core_clk_i);
    issue_valid_o <= 1'b0;
    first_local_operand_o <= ~a;
    second_local_operand_o <= ~b;
  endtask

  task automatic set_fcr(input logic [31:0] v);
    @(posedge core_clk_i);
    float_control_register_o <= v;
  endtask
endmodule

//--- dv/extended_dsp_mac_unit_test.sv
// Self-checking bench for the extended multiply-accumulate unit
`timescale 1ns/1ps
`include "xmac_map.svh"
module extended_dsp_mac_unit_test;
  logic core_clk_i;
  logic rst_i;
  logic issue_valid;
  logic [3:0] op_code;
  logic [3:0] op_a;
  logic [3:0] op_b;
  logic [31:0] float_control_register;
  logic lreg_we;
  logic [3:0] lreg_waddr;
  logic [31:0] lreg_wdata;
  logic g_we;
  logic g_sel_15;
  logic [31:0] g_wdata;
  logic busy;
  logic [31:0] g14;
  logic [31:0] g15;
  logic wb_valid;
  logic wb_double;
  logic ovf;
  logic [31:0] exp_g14;
  logic [31:0] exp_g15;
  int n_errors;
  int tests_run;

  xmac_unit i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .issue_valid_i(issue_valid), .op_code_i(op_code),
    .first_local_operand_i(op_a), .second_local_operand_i(op_b),
    .float_control_register_i(float_control_register), .lreg_we_i(lreg_we),
    .lreg_waddr_i(lreg_waddr), .lreg_wdata_i(lreg_wdata), .g_we_i(g_we),
    .g_sel_15_i(g_sel_15), .g_wdata_i(g_wdata), .busy_o(busy),
    .global_register_14_o(g14), .global_register_15_o(g15),
    .wb_valid_o(wb_valid), .wb_double_o(wb_double), .ovf_exc_o(ovf));

  xmac_core_model i_core (.core_clk_i(core_clk_i),
    .issue_valid_o(issue_valid), .op_code_o(op_code),
    .first_local_operand_o(op_a), .second_local_operand_o(op_b),
    .float_control_register_o(float_control_register), .lreg_we_o(lreg_we),
    .lreg_waddr_o(lreg_waddr), .lreg_wdata_o(lreg_wdata), .g_we_o(g_we),
    .g_sel_15_o(g_sel_15), .g_wdata_o(g_wdata));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Result {double, overflow, g14, g15} from the tracked globals
  function automatic logic [65:0] mac_ref(input logic [3:0] op,
      input logic [31:0] a, input logic [31:0] b);
    logic signed [127:0] p;
    logic signed [127:0] hp;
    logic signed [127:0] r;
    logic dbl;
    logic ov;
    p = $signed(a) * $signed(b);
    hp = $signed(a[31:16]) * $signed(b[31:16])
       + $signed(a[15:0]) * $signed(b[15:0]);
    dbl = op inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h8};
    case (op)
      4'h0: r = $signed(exp_g15) + hp;
      4'h1: r = $signed({exp_g14, exp_g15}) + hp;
      4'h2: r = $signed(exp_g15) + p;
      4'h3: r = $signed({exp_g14, exp_g15}) + p;
      4'h4: r = $signed(exp_g15) - p;
      4'h5: r = $signed({exp_g14, exp_g15}) - p;
      4'h8: r = $signed({96'h0, a} * {96'h0, b});
      default: r = p;
    endcase
    ov = dbl ? (r !== {{64{r[63]}}, r[63:0]})
             : (r !== {{96{r[31]}}, r[31:0]});
    if (op > 4'h5) ov = 1'b0;
    if (!dbl) r[63:32] = exp_g14;
    return {dbl, ov, r[63:0]};
  endfunction

  task automatic mv(input logic sel, input logic [31:0] v);
    i_core.move_global(sel, v);
    if (sel) exp_g15 = v;
    else exp_g14 = v;
  endtask

  task automatic run_op(input logic [3:0] op, input logic [3:0] ai,
      input logic [3:0] bi);
    logic [65:0] e;
    int n;
    e = mac_ref(op, i_core.loc[ai], i_core.loc[bi]);
    i_core.issue_op(op, ai, bi);
    #1;
    check("busy", busy, 64'h1);
    n = 0;
    while (wb_valid !== 1'b1 && n < 8) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check("latency", n, 64'(`XM_BUSY_CYCLES));
    check("wb_double", wb_double, e[65]);
    check("ovf", ovf, e[64] & ~float_control_register[16]);
    check("g14", g14, e[63:32]);
    check("g15", g15, e[31:0]);
    {exp_g14, exp_g15} = e[63:0];
  endtask

  task automatic t_reset;
    check("busy", busy, 64'h0);
    check("wb_valid", wb_valid, 64'h0);
    check("ovf", ovf, 64'h0);
    check("g14", g14, `XM_G_RST);
    check("g15", g15, `XM_G_RST);
    $display("test reset done");
  endtask

  task automatic t_ops;
    for (int i = 0; i < 16; i++) begin
      i_core.write_local(4'(i), 32'h9E37_79B9 * (i + 1));
    end
    mv(1'b0, 32'h0123_4567);
    mv(1'b1, 32'h89AB_CDEF);
    for (int op = 0; op < 9; op++) begin
      run_op(4'(op), 4'(op), 4'(15 - op));
    end
    $display("test all ops done");
  endtask

  task automatic t_ovf;
    i_core.write_local(4'h0, 32'h0000_0001);
    i_core.write_local(4'h1, 32'h0001_0001);
    i_core.write_local(4'h2, 32'h0001_0000);
    for (int f = 0; f < 2; f++) begin
      i_core.set_fcr({15'h0, f[0], 16'h0});
      mv(1'b1, 32'h7FFF_FFFF);
      run_op(4'h2, 4'h0, 4'h0);
      mv(1'b1, 32'h7FFF_FFFF);
      run_op(4'h0, 4'h1, 4'h1);
      mv(1'b0, 32'h8000_0000);
      mv(1'b1, 32'h0000_0000);
      run_op(4'h5, 4'h0, 4'h0);
      run_op(4'h6, 4'h2, 4'h2);
    end
    $display("test overflow done");
  endtask

  task automatic t_busy;
    logic [65:0] e;
    int n;
    e = mac_ref(4'h6, i_core.loc[4'h3], i_core.loc[4'h4]);
    i_core.issue_op(4'h6, 4'h3, 4'h4);
    i_core.issue_op(4'h7, 4'h5, 4'h6);
    #1;
    check("wb_valid", wb_valid, 64'h1);
    check("g15", g15, e[31:0]);
    {exp_g14, exp_g15} = e[63:0];
    n = 0;
    repeat (5) begin
      @(posedge core_clk_i);
      #1;
      if (wb_valid === 1'b1) n++;
    end
    check("refused", n, 64'h0);
    e = mac_ref(4'h2, i_core.loc[4'h7], i_core.loc[4'h8]);
    i_core.issue_op(4'h2, 4'h7, 4'h8);
    i_core.move_global(1'b1, 32'hDEAD_BEEF);
    #1;
    check("g15", g15, e[31:0]);
    mv(1'b1, 32'h5555_AAAA);
    #1;
    check("g15", g15, exp_g15);
    i_core.issue_op(4'h9, 4'h3, 4'h4);
    #1;
    check("illegal", busy, 64'h0);
    @(posedge core_clk_i);
    #1;
    check("illegal_wb", wb_valid, 64'h0);
    $display("test busy done");
  endtask

  initial begin
    repeat (3000) @(posedge core_clk_i);
    n_errors++;
    stop_test();
  end

  initial begin
    n_errors = 0;
    tests_run = 0;
    rst_i = 1'b1;
    exp_g14 = `XM_G_RST;
    exp_g15 = `XM_G_RST;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_ops();
    t_ovf();
    t_busy();
    stop_test();
  end
endmodule
